// file: core/lbhp_map.svh
// Constants of the local bus host port
//
// Operation
// R1: Claim a cycle only when address and memory/IO decode hit our windows.
// R2: Drive the claim low before the middle of the first T2 after strobe.
// R3: The claim pin is open-collector: drive it low only, else release it.
// R4: Memory/IO qualifier high means a memory cycle, low means an I/O cycle.
// R5: Write/read qualifier high means a write, low means a read.
// R6: Pipelined bus: watch ready as input, drive it low to end our cycles.
// R7: Burst bus: the ready pin is burst ready, driven low to end our cycles.
// R8: Burst bus: the processor's burst-last marks the final transfer.
// R9: Burst bus: drive the low-half transceiver enable, data bits 15 to 0.
// R10: Burst bus: drive the high-half transceiver enable, data bits 31 to 16.
// R11: Other buses: three shared pins are active-low switches for software.
// R12: While reset is high, outputs float and registers take reset values.
// R13: When reset returns low, normal operation begins.
// R14: The vertical retrace end register governs the three-state interrupt.
// R15: In suspend, time refresh from the external slow clock when supplied.
`ifndef LBHP_MAP_SVH
`define LBHP_MAP_SVH
// ----------------------------------------
// Decode windows (address bits 23:2)
// ----------------------------------------
`define LBHP_MEM_BASE 22'h028000
`define LBHP_MEM_MASK 22'h3f8000
`define LBHP_IO_BASE 22'h0000f0
`define LBHP_IO_MASK 22'h3ffff0
// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define LBHP_WAIT_STATES 2'h1
`define LBHP_REFRESH_DIV 9'h1f3
`define LBHP_IRQ_ENABLE_BIT 5
`define LBHP_IRQ_CLEAR_N_BIT 4
`define LBHP_VRE_RESET 8'h00
`endif

// file: core/lbhp_pkg.sv
// Types of the local bus host port
package lbhp_pkg;
  // Bus variant strap
  typedef enum logic [1:0] {
    LBHP_BUS_ISA = 2'h1,
    LBHP_BUS_PIPE = 2'h2
  } lbhp_bus_t;
  // Cycle qualifiers from the processor
  typedef struct packed {
    logic [21:0] addr;
    logic mem_io;
    logic wr_rd;
  } lbhp_cyc_t;
  // Cycle sequencer states
  typedef enum logic [3:0] {
    LBHP_IDLE = 4'h1,
    LBHP_T2 = 4'h2,
    LBHP_WAIT = 4'h4,
    LBHP_DONE = 4'h8
  } lbhp_st_t;
endpackage : lbhp_pkg

// file: core/lbhp_refresh_tick.sv
// Suspend refresh tick generator
`timescale 1ns/1ps
`include "lbhp_map.svh"
module lbhp_refresh_tick (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic suspend,
  input wire logic suspend_refresh_clock,
  input wire logic use_ext_clock,
  output logic refresh_tick
);
  logic [8:0] div_r;
  logic ext_d1_r;
  logic ext_d2_r;
  logic ext_d3_r;
  wire div_hit = (div_r == `LBHP_REFRESH_DIV);
  wire ext_rise = ext_d2_r & ~ext_d3_r;
  // Slow external clock is sampled; it is far below the system rate
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_d1_r <= 1'b0;
      ext_d2_r <= 1'b0;
      ext_d3_r <= 1'b0;
    end else begin
      ext_d1_r <= suspend_refresh_clock;
      ext_d2_r <= ext_d1_r;
      ext_d3_r <= ext_d2_r;
    end
  end
  // Internal fallback divider when no external clock is fitted
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 9'h000;
    end else begin
      div_r <= div_hit ? 9'h000 : div_r + 9'h001;
    end
  end
  // R15: refresh timing source
  assign refresh_tick = suspend & (use_ext_clock ? ext_rise : div_hit);
endmodule : lbhp_refresh_tick

// file: core/lbhp_host_port.sv
// Local bus host port: claim, ready, transceiver enables, switches, irq
`timescale 1ns/1ps
`include "lbhp_map.svh"
module lbhp_host_port (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic burst_bus,
  input wire logic ads_n,
  input wire logic [21:0] addr,
  input wire logic mem_io,
  input wire logic wr_rd,
  input wire logic ready_in_n,
  input wire logic blast_n,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  input wire logic pin_c_in,
  input wire logic [7:0] vre_wdata,
  input wire logic vre_we,
  input wire logic retrace_event,
  input wire logic suspend,
  input wire logic suspend_refresh_clock,
  input wire logic use_ext_clock,
  output logic cycle_claim_n_o,
  output logic cycle_claim_n_oe,
  output logic ready_o,
  output logic ready_oe,
  output logic pin_a_o,
  output logic pin_a_oe,
  output logic pin_c_o,
  output logic pin_c_oe,
  output logic [2:0] switch_state,
  output logic cycle_is_write,
  output logic cycle_is_mem,
  output logic irq_o,
  output logic irq_oe,
  output logic refresh_tick
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic win_hit(input logic [21:0] a,
                                   input logic [21:0] base,
                                   input logic [21:0] mask);
    win_hit = ((a & mask) == base);
  endfunction : win_hit

  lbhp_pkg::lbhp_cyc_t cyc;
  lbhp_pkg::lbhp_st_t st_r;
  lbhp_pkg::lbhp_st_t st_nxt;
  logic [1:0] wait_r;
  logic claim_r;
  logic write_r;
  logic mem_r;
  logic busy_other_r;
  logic [2:0] sw_r;
  logic [7:0] vre_r;
  logic irq_r;

  assign cyc = '{addr: addr, mem_io: mem_io, wr_rd: wr_rd};
  // R4: memory window when high, I/O window when low
  // R1: claim only our own resources
  wire hit = cyc.mem_io ? win_hit(cyc.addr, `LBHP_MEM_BASE, `LBHP_MEM_MASK)
                        : win_hit(cyc.addr, `LBHP_IO_BASE, `LBHP_IO_MASK);
  wire start = ~ads_n & hit;
  wire wait_done = (wait_r == `LBHP_WAIT_STATES);
  wire last_xfer = ~burst_bus | ~blast_n;

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      lbhp_pkg::LBHP_IDLE: if (start) st_nxt = lbhp_pkg::LBHP_T2;
      lbhp_pkg::LBHP_T2: st_nxt = lbhp_pkg::LBHP_WAIT;
      lbhp_pkg::LBHP_WAIT: if (wait_done) st_nxt = lbhp_pkg::LBHP_DONE;
      // R8: stay claimed until burst-last on the final transfer
      lbhp_pkg::LBHP_DONE: if (last_xfer) st_nxt = lbhp_pkg::LBHP_IDLE;
      default: st_nxt = lbhp_pkg::LBHP_IDLE;
    endcase
  end

  // R12: all state back to reset values
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= lbhp_pkg::LBHP_IDLE;
      wait_r <= 2'h0;
      claim_r <= 1'b0;
      write_r <= 1'b0;
      mem_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wait_r <= (st_r == lbhp_pkg::LBHP_WAIT) ? wait_r + 2'h1 : 2'h0;
      // R2: claim registered at the end of T1, so it leads T2
      claim_r <= (st_nxt != lbhp_pkg::LBHP_IDLE);
      if (start && st_r == lbhp_pkg::LBHP_IDLE) begin
        // R5: write when high, read when low
        write_r <= cyc.wr_rd;
        mem_r <= cyc.mem_io;
      end
    end
  end

  // R6: follow cycles that miss our windows, and that other slaves answer, through ready as an input
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_other_r <= 1'b0;
    end else if (!ads_n && !hit) begin
      busy_other_r <= 1'b1;
    end else if (!ready_in_n) begin
      busy_other_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  wire ending = (st_r == lbhp_pkg::LBHP_DONE);
  // R3: open collector, low or released
  assign cycle_claim_n_o = 1'b0;
  assign cycle_claim_n_oe = claim_r;
  // R6: ready driven low only to end our own cycle
  // R7: same pin as burst ready on the burst bus
  assign ready_o = 1'b0;
  assign ready_oe = ending & ~busy_other_r;
  // R9: low-half enable while our cycle owns the data path
  assign pin_a_o = ~claim_r;
  // R10: high-half enable alongside
  assign pin_c_o = ~claim_r;
  // R12: enables float while reset holds, whatever the strap says
  assign pin_a_oe = burst_bus & rst_b;
  assign pin_c_oe = burst_bus & rst_b;
  assign cycle_is_write = write_r;
  assign cycle_is_mem = mem_r;

  // ----------------------------------------
  // Switches and interrupt control
  // ----------------------------------------
  // R11: shared pins read as active-low switches off the burst bus
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sw_r <= 3'h0;
    end else if (!burst_bus) begin
      sw_r <= ~{pin_c_in, pin_b_in, pin_a_in};
    end
  end
  assign switch_state = sw_r;

  // R14: control register steers the interrupt; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vre_r <= `LBHP_VRE_RESET;
      irq_r <= 1'b0;
    end else begin
      if (vre_we) vre_r <= vre_wdata;
      if (retrace_event) begin
        irq_r <= 1'b1;
      end else if (vre_we && !vre_wdata[`LBHP_IRQ_CLEAR_N_BIT]) begin
        irq_r <= 1'b0;
      end
    end
  end
  // Enable bit low means interrupt on; floats otherwise and in reset
  // R12: reset value of the register alone would leave it driven
  assign irq_oe = ~vre_r[`LBHP_IRQ_ENABLE_BIT] & rst_b;
  assign irq_o = irq_r;

  // R15: suspend refresh timing
  lbhp_refresh_tick u_refresh (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .suspend(suspend),
    .suspend_refresh_clock(suspend_refresh_clock),
    .use_ext_clock(use_ext_clock),
    .refresh_tick(refresh_tick)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_claim_on_hit: assert property ( // R2
    @(posedge clk_sys) disable iff (!rst_b)
    (st_r == lbhp_pkg::LBHP_IDLE && start) |=> cycle_claim_n_oe)
    else $error("claim not driven in T2");
  a_claim_only_hit: assert property ( // R1
    @(posedge clk_sys) disable iff (!rst_b)
    (st_r == lbhp_pkg::LBHP_IDLE && !start) |=> !cycle_claim_n_oe)
    else $error("claim without decode hit");
  a_ready_timing: assert property ( // R6
    @(posedge clk_sys) disable iff (!rst_b)
    (st_r == lbhp_pkg::LBHP_T2) |=> ##2 ending)
    else $error("ready not reached after waits");
  a_burst_hold: assert property ( // R8
    @(posedge clk_sys) disable iff (!rst_b)
    (ending && burst_bus && blast_n) |=> ending)
    else $error("burst left before last");
  a_xcvr_low: assert property ( // R9
    @(posedge clk_sys) disable iff (!rst_b)
    (burst_bus && st_r != lbhp_pkg::LBHP_IDLE) |-> (pin_a_oe && !pin_a_o))
    else $error("low enable not driven in cycle");
  a_xcvr_high: assert property ( // R10
    @(posedge clk_sys) disable iff (!rst_b)
    (burst_bus && st_r != lbhp_pkg::LBHP_IDLE) |-> (pin_c_oe && !pin_c_o))
    else $error("high enable not driven in cycle");
  a_pins_float: assert property ( // R11
    @(posedge clk_sys) disable iff (!rst_b)
    !burst_bus |-> (!pin_c_oe && !pin_a_oe))
    else $error("enables driven off burst bus");
  a_switch_read: assert property ( // R11
    @(posedge clk_sys) disable iff (!rst_b)
    !burst_bus |=>
      (switch_state == ~$past({pin_c_in, pin_b_in, pin_a_in})))
    else $error("switch state stale");
  a_irq_sticky: assert property ( // R14
    @(posedge clk_sys) disable iff (!rst_b)
    retrace_event |=> irq_r)
    else $error("interrupt event lost");
endmodule : lbhp_host_port

// file: sim/lbhp_cpu_pins.sv
// Processor-side wiring of the claim and ready pins, with pull-ups
`timescale 1ns/1ps
module lbhp_cpu_pins (
  input wire logic claim_o,
  input wire logic claim_oe,
  input wire logic rdy_o,
  input wire logic rdy_oe,
  input wire logic other_rdy_n,
  output logic claim_pin,
  output logic ready_pin
);
  // pull-up resolves released pins
  // A floating pin must read high, never the last driven level
  assign claim_pin = claim_oe ? claim_o : 1'b1;
  // Ready is wired-AND with another slave that answers our misses
  assign ready_pin = (rdy_oe ? rdy_o : 1'b1) & other_rdy_n;
endmodule : lbhp_cpu_pins

// file: sim/testbench.sv
// Self-checking bench of the local bus host port
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 0, rst_b = 0, burst_bus = 0, ads_n = 1, mem_io = 1;
  logic wr_rd = 0, blast_n = 1, pa = 1, pb = 1, pc = 1, vre_we = 0;
  logic retrace_event = 0, suspend = 0, src = 0, use_ext = 0, other_rdy_n = 1;
  logic [21:0] addr = 22'h000000;
  logic [7:0] vre_wdata = 8'h00;
  logic claim_o, claim_oe, rdy_o, rdy_oe, claim_pin, ready_pin, irq_o;
  logic irq_oe, pa_o, pa_oe, pc_o, pc_oe, is_wr, is_mem, tick;
  logic [2:0] sw;
  int n_fail = 0, comparisons = 0, n;
  initial forever #25 clk_sys = ~clk_sys;
  lbhp_host_port uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .burst_bus(burst_bus), .ads_n(ads_n), .addr(addr), .mem_io(mem_io),
    .wr_rd(wr_rd), .ready_in_n(ready_pin), .blast_n(blast_n),
    .pin_a_in(pa), .pin_b_in(pb), .pin_c_in(pc), .vre_wdata(vre_wdata),
    .vre_we(vre_we), .retrace_event(retrace_event), .suspend(suspend),
    .suspend_refresh_clock(src), .use_ext_clock(use_ext),
    .cycle_claim_n_o(claim_o), .cycle_claim_n_oe(claim_oe),
    .ready_o(rdy_o), .ready_oe(rdy_oe), .pin_a_o(pa_o), .pin_a_oe(pa_oe),
    .pin_c_o(pc_o), .pin_c_oe(pc_oe), .switch_state(sw),
    .cycle_is_write(is_wr), .cycle_is_mem(is_mem), .irq_o(irq_o),
    .irq_oe(irq_oe), .refresh_tick(tick));
  lbhp_cpu_pins cpu (.claim_o(claim_o), .claim_oe(claim_oe),
    .rdy_o(rdy_o), .rdy_oe(rdy_oe), .claim_pin(claim_pin),
    .ready_pin(ready_pin), .other_rdy_n(other_rdy_n));
  // Compare, count, report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  // One processor cycle; misses must never be claimed
  task automatic bus(input logic [21:0] a, input logic m, w, hit);
    @(posedge clk_sys);
    ads_n <= 1'b0;
    addr <= a;
    mem_io <= m;
    wr_rd <= w;
    @(posedge clk_sys);
    ads_n <= 1'b1;
    #1;
    chk(claim_pin, !hit);
    n = 0;
    while (ready_pin !== 1'b0 && n < 12) begin
      step(1);
      n++;
      if (!hit) chk({claim_pin, rdy_oe}, 2'b10);
      // Another slave ends the cycle that we let pass
      if (!hit && n == 4) other_rdy_n <= 1'b0;
    end
    other_rdy_n <= 1'b1;
    if (n == 12) begin
      n_fail++;
      results();
    end
    chk(n[7:0], hit ? 8'h03 : 8'h05);
    if (hit) begin
      chk({claim_pin, is_wr, is_mem}, {1'b0, w, m});
      chk({pa_oe, pc_oe, pa_o, pc_o}, {{2{burst_bus}}, 2'b00});
      if (burst_bus) begin
        step(1);
        chk(ready_pin, 1'b0);
        blast_n <= 1'b0;
      end
      step(1);
      blast_n <= 1'b1;
      chk({claim_pin, ready_pin, pa_o, pc_o}, 4'hf);
    end
  endtask : bus
  task automatic vre(input logic [7:0] d);
    @(posedge clk_sys);
    vre_wdata <= d;
    vre_we <= 1'b1;
    @(posedge clk_sys);
    vre_we <= 1'b0;
  endtask : vre
  // Counts refresh ticks; slow clock period is 64 bus cycles
  task automatic ticks(input int k);
    n = 0;
    for (int i = 0; i < k; i++) begin
      @(posedge clk_sys);
      src <= i[5];
      #1;
      if (tick === 1'b1) n++;
    end
  endtask : ticks
  task automatic results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(2);
    chk({claim_oe, rdy_oe, pa_oe, pc_oe, irq_oe, irq_o}, 6'h00);
    step(6);
    rst_b <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys);
      burst_bus <= b[0];
      bus(22'h028000, 1'b1, 1'b1, 1'b1);
      bus(22'h02ffff, 1'b1, 1'b0, 1'b1);
      bus(22'h0000f0, 1'b0, 1'b1, 1'b1);
      bus(22'h0000ff, 1'b0, 1'b0, 1'b1);
      bus(22'h0000f0, 1'b1, 1'b0, 1'b0);
      bus(22'h028000, 1'b0, 1'b1, 1'b0);
      bus(22'h030000, 1'b1, 1'b1, 1'b0);
    end
    // Switches only on the other buses
    burst_bus <= 1'b0;
    pa <= 1'b0;
    pc <= 1'b0;
    step(3);
    chk(sw, 3'h5);
    pa <= 1'b1;
    pb <= 1'b0;
    step(3);
    chk(sw, 3'h6);
    vre(8'h10);
    step(1);
    chk(irq_oe, 1'b1);
    @(posedge clk_sys);
    retrace_event <= 1'b1;
    @(posedge clk_sys);
    retrace_event <= 1'b0;
    step(2);
    chk(irq_o, 1'b1);
    vre(8'h00);
    step(2);
    chk(irq_o, 1'b0);
    // Event and clear in one cycle: the event must win
    @(posedge clk_sys);
    retrace_event <= 1'b1;
    vre_wdata <= 8'h00;
    vre_we <= 1'b1;
    @(posedge clk_sys);
    retrace_event <= 1'b0;
    vre_we <= 1'b0;
    step(2);
    chk(irq_o, 1'b1);
    vre(8'h30);
    step(2);
    chk({irq_oe, irq_o}, 2'b01);
    ticks(600);
    chk(n[7:0], 8'h00);
    suspend <= 1'b1;
    ticks(500);
    chk(n[7:0], 8'h01);
    use_ext <= 1'b1;
    ticks(500);
    chk(n[7:0], 8'h08);
    results();
  end
endmodule : testbench
